// *** src/dpa_adc_core.sv ***
// Function
// RULE1: output word for a sample appears after the sixth sample-clock cycle
// RULE2: after latency, one new word per channel every cycle, in order
// RULE3: each word is eight-bit offset binary, bit seven most significant
// RULE4: full positive gives all ones, full negative all zeros
// RULE5: non-overlapping two-phase clock made from the single sample clock
// RULE6: sample captured at end of phase one, held during phase two
// RULE7: stages alternate sample and amplify phases, neighbours inverted
// RULE8: middle stages give two bits with redundancy, last is two-bit flash
// RULE9: delay line aligns all stage results of one sample with flash
// RULE10: correction folds aligned results into the final eight-bit word
// RULE11: receiver discards words for up to twenty cycles after power-up
// RULE12: receiver captures both channel buses on the same clock edge
`timescale 1ns/1ps
`default_nettype none
module dpa_adc_core
(
   // clock and reset
   input  wire logic                                clk_i,
   input  wire logic                                arst_n_i,
   input  wire logic                                ce_i,
   // external sample clock pin
   input  wire logic                                smp_clk_i,
   // comparator decisions per channel
   input  wire logic [dpa_pkg::CH_NUM-1:0][dpa_pkg::STG_NUM-1:0][1:0]
                                                    stg_code_i,
   input  wire logic [dpa_pkg::CH_NUM-1:0][1:0]     flash_code_i,
   // internal phases
   output var  logic                                phi1_o,
   output var  logic                                phi2_o,
   // output buses
   output var  logic [dpa_pkg::CH_NUM-1:0][dpa_pkg::WORD_W-1:0]
                                                    chan_out_o,
   output var  logic                                lat_done_o
);
   import dpa_pkg::*;

   logic [SYNC_DEPTH-1:0] sync_ff;
   logic                  lvl_ff;
   logic                  phi1_ff;
   logic                  phi2_ff;
   logic                  nxt_phi1;
   logic                  nxt_phi2;
   logic                  p1_end;
   logic                  p2_end;
   logic                  cyc;
   logic [LAT_CNT_W-1:0]  lat_ff;
   logic                  lat_done_ff;
   dpa_word_t             word [CH_NUM];

   // pin crosses into clk_i; only the second flop feeds logic
   always_ff @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
         sync_ff <= '0;
      else if (ce_i)
         sync_ff <= {sync_ff[0], smp_clk_i};
   end

   always_ff @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
         lvl_ff <= 1'b0;
      else if (ce_i)
         lvl_ff <= sync_ff[1];
   end

   // a phase is on only when two samples agree, so each level change
   // leaves one idle cycle between phases
   always_comb
   begin
      nxt_phi1 = sync_ff[1] & lvl_ff;                       // [RULE5]
      nxt_phi2 = ~sync_ff[1] & ~lvl_ff;                     // [RULE5]
   end

   always_ff @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         phi1_ff <= 1'b0;
         phi2_ff <= 1'b0;
      end
      else if (ce_i)
      begin
         phi1_ff <= nxt_phi1;
         phi2_ff <= nxt_phi2;
      end
   end

   // sampler closes as phase one falls; hold settles through phase two
   assign p1_end = phi1_ff & ~nxt_phi1;                     // [RULE6]
   assign p2_end = phi2_ff & ~nxt_phi2;                     // [RULE6] [RULE7]
   assign cyc    = ~phi1_ff & nxt_phi1;

   assign phi1_o = phi1_ff;
   assign phi2_o = phi2_ff;

   for (genvar c = 0; c < CH_NUM; c++)
   begin : g_ch
      dpa_align_if u_al ();

      // odd stages decide at end of phase one, even at end of phase two
      dpa_delay_line u_dly                                  // [RULE8]
      (
         .clk_i    (clk_i),
         .arst_n_i (arst_n_i),
         .ce_i     (ce_i),
         .p1_end_i (p1_end),
         .p2_end_i (p2_end),
         .stg_i    (stg_code_i[c]),
         .flash_i  (flash_code_i[c]),
         .al       (u_al.dly)
      );

      dpa_corrector u_corr
      (
         .clk_i    (clk_i),
         .arst_n_i (arst_n_i),
         .ce_i     (ce_i),
         .cyc_i    (cyc),
         .al       (u_al.corr),
         .word_o   (word[c])
      );

      assign chan_out_o[c] = word[c];                       // [RULE3]
   end

   // marks when the first real sample has reached the bus; the receiver
   // still owns power-up discard, this flag only helps it
   always_ff @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         lat_ff      <= LAT_RST;
         lat_done_ff <= 1'b0;
      end
      else if (ce_i && cyc && !lat_done_ff)
      begin
         lat_ff <= lat_ff + 3'h1;
         if (lat_ff == 3'(OUTPUT_LATENCY))
            lat_done_ff <= 1'b1;                            // [RULE1] [RULE11]
      end
   end

   assign lat_done_o = lat_done_ff;

   a_no_overlap: assert property (                          // [RULE5]
      @(posedge clk_i) disable iff (!arst_n_i)
      !(phi1_ff && phi2_ff))
      else $error("phases overlap");

   sequence s_p1_fall;
      $fell(phi1_ff);
   endsequence

   a_gap_after_p1: assert property (                        // [RULE5]
      @(posedge clk_i) disable iff (!arst_n_i)
      s_p1_fall |-> !phi2_ff)
      else $error("phase two started without a gap");

   a_sample_edge: assert property (                         // [RULE6]
      @(posedge clk_i) disable iff (!arst_n_i)
      (ce_i && p1_end) |=> !phi1_ff && !phi2_ff)
      else $error("sample instant not followed by idle gap");

   a_lat_flag: assert property (                            // [RULE1]
      @(posedge clk_i) disable iff (!arst_n_i)
      $rose(lat_done_ff) |-> $past(lat_ff) == 3'(OUTPUT_LATENCY))
      else $error("latency flag rose at wrong count");

   // enable low must stop the phase generator and the latency count
   sequence s_frozen;
      !ce_i;
   endsequence

   a_hold_frozen: assert property (                         // [RULE5]
      @(posedge clk_i) disable iff (!arst_n_i)
      s_frozen |=> $stable(phi1_ff) && $stable(phi2_ff) && $stable(lat_ff))
      else $error("state moved while clock enable was low");

endmodule
`default_nettype wire

// *** src/dpa_align_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface dpa_align_if;
   import dpa_pkg::*;
   dpa_stg_vec_t    stg;     // aligned stage results of one sample
   logic [STG_W-1:0] flash;  // last-stage flash result, same sample
   logic            vld;     // one-cycle strobe, all fields belong together

   modport dly
   (
      output stg,
      output flash,
      output vld
   );
   modport corr
   (
      input  stg,
      input  flash,
      input  vld
   );
endinterface
`default_nettype wire

// *** src/dpa_corrector.sv ***
`timescale 1ns/1ps
`default_nettype none
module dpa_corrector
(
   // clock and reset
   input  wire logic             clk_i,
   input  wire logic             arst_n_i,
   input  wire logic             ce_i,
   // cycle start, advances the output pipe
   input  wire logic             cyc_i,
   // aligned side
   dpa_align_if.corr             al,
   // corrected word
   output var  dpa_pkg::dpa_word_t word_o
);
   import dpa_pkg::*;

   dpa_word_t corr_ff;
   dpa_word_t pipe_ff [OUT_EXTRA];
   dpa_word_t nxt_corr;

   // weighted sum of redundant stages; overlap between stages absorbs
   // comparator offsets, so no carry fix-up is needed here
   function automatic dpa_word_t dpa_fold(input dpa_stg_vec_t s,
                                          input logic [1:0]  f);
      logic [8:0] acc;
      acc = {7'h00, f};
      for (int k = 0; k < STG_NUM; k++)
         acc = acc + ({7'h00, dpa_sat(s[k])} << (STG_NUM - k));
      dpa_fold = acc[7:0];
   endfunction

   always_comb
   begin
      nxt_corr = dpa_fold(al.stg, al.flash);                // [RULE10] [RULE3]
   end

   always_ff @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
         corr_ff <= WORD_RST;
      else if (ce_i && al.vld)
         corr_ff <= nxt_corr;                               // [RULE10]
   end

   always_ff @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         for (int i = 0; i < OUT_EXTRA; i++)
            pipe_ff[i] <= WORD_RST;
      end
      else if (ce_i && cyc_i)
      begin
         pipe_ff[0] <= corr_ff;                             // [RULE1] [RULE2]
         for (int i = 1; i < OUT_EXTRA; i++)
            pipe_ff[i] <= pipe_ff[i-1];
      end
   end

   assign word_o = pipe_ff[OUT_EXTRA-1];

   a_full_code: assert property (                           // [RULE4]
      @(posedge clk_i) disable iff (!arst_n_i)
      (ce_i && al.vld && al.stg == {STG_NUM{CODE_MAX}} && al.flash == 2'h3)
      |=> corr_ff == WORD_FULL)
      else $error("top code did not give all ones");

   a_zero_code: assert property (                           // [RULE4]
      @(posedge clk_i) disable iff (!arst_n_i)
      (ce_i && al.vld && al.stg == '0 && al.flash == 2'h0)
      |=> corr_ff == WORD_ZERO)
      else $error("bottom code did not give all zeros");

   a_out_moves: assert property (                           // [RULE2]
      @(posedge clk_i) disable iff (!arst_n_i)
      $changed(word_o) |-> $past(ce_i && cyc_i))
      else $error("output word changed off a cycle start");

endmodule
`default_nettype wire

// *** src/dpa_delay_line.sv ***
`timescale 1ns/1ps
`default_nettype none
module dpa_delay_line
(
   // clock and reset
   input  wire logic                   clk_i,
   input  wire logic                   arst_n_i,
   input  wire logic                   ce_i,
   // phase events
   input  wire logic                   p1_end_i,
   input  wire logic                   p2_end_i,
   // raw stage decisions
   input  wire dpa_pkg::dpa_stg_vec_t  stg_i,
   input  wire logic [1:0]             flash_i,
   // aligned side
   dpa_align_if.dly                    al
);
   import dpa_pkg::*;

   logic half_ev;

   // every phase end moves the line; stage k lands one half-cycle after k-1
   assign half_ev = p1_end_i | p2_end_i;

   for (genvar k = 0; k < STG_NUM; k++)
   begin : g_stg
      localparam int unsigned DEPTH = STG_NUM - k;
      logic [1:0] sr_ff [DEPTH];

      always_ff @(posedge clk_i or negedge arst_n_i)
      begin
         if (!arst_n_i)
         begin
            for (int i = 0; i < DEPTH; i++)
               sr_ff[i] <= STG_RST;
         end
         else if (ce_i && half_ev)
         begin
            sr_ff[0] <= stg_i[k];                           // [RULE9]
            for (int i = 1; i < DEPTH; i++)
               sr_ff[i] <= sr_ff[i-1];
         end
      end

      assign al.stg[k] = sr_ff[DEPTH-1];
   end

   // flash output needs no delay: it is the last to arrive
   assign al.flash = flash_i;
   assign al.vld   = ce_i & p2_end_i;                       // [RULE9]

   a_events_apart: assert property (                        // [RULE7]
      @(posedge clk_i) disable iff (!arst_n_i)
      !(p1_end_i && p2_end_i))
      else $error("both phases ended in one cycle");

endmodule
`default_nettype wire

// *** src/dpa_pkg.sv ***
`default_nettype none
package dpa_pkg;
   // converter shape
   localparam int unsigned CH_NUM       = 2;
   localparam int unsigned WORD_W       = 8;
   localparam int unsigned STG_NUM      = 6;   // redundant two-bit stages
   localparam int unsigned STG_W        = 2;
   localparam int unsigned SYNC_DEPTH   = 2;

   // timing, in sample-clock cycles
   localparam int unsigned OUTPUT_LATENCY = 6;
   // stage results meet the corrector at end of phase two, cycle n+3
   localparam int unsigned ALIGN_CYC      = 3;
   localparam int unsigned OUT_EXTRA      = OUTPUT_LATENCY - ALIGN_CYC;
   localparam int unsigned LAT_CNT_W      = 3;

   // stage decision codes
   localparam logic [1:0] CODE_MAX = 2'h2;  // 2'h3 is illegal, folded to 2

   // reset values and code points
   localparam logic [7:0] WORD_RST  = 8'h00;
   localparam logic [7:0] WORD_FULL = 8'hff;
   localparam logic [7:0] WORD_ZERO = 8'h00;
   localparam logic [1:0] STG_RST   = 2'h0;
   localparam logic [2:0] LAT_RST   = 3'h0;

   typedef logic [STG_NUM-1:0][STG_W-1:0] dpa_stg_vec_t;
   typedef logic [WORD_W-1:0]             dpa_word_t;

   // saturate a redundant stage code onto its legal range
   function automatic logic [1:0] dpa_sat(input logic [1:0] c);
      dpa_sat = (c > CODE_MAX) ? CODE_MAX : c;
   endfunction
endpackage
`default_nettype wire

// *** testbench/dpa_rx_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module dpa_rx_model
(
   // clock and reset
   input  wire logic            clk_i,
   input  wire logic            arst_n_i,
   // device side
   input  wire logic            phi1_i,
   input  wire logic [1:0][7:0] chan_i,
   // captured pair
   output var  logic [1:0][7:0] pair_o,
   output var  logic            vld_o
);
   logic       phi1_d_ff;
   logic [4:0] seen_ff;

   // both buses taken on one edge, as one pair
   always_ff @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         phi1_d_ff <= 1'b0;
         pair_o    <= '0;
      end
      else
      begin
         phi1_d_ff <= phi1_i;
         if (phi1_i && !phi1_d_ff)
            pair_o <= chan_i;
      end
   end

   // words before the power-up span are thrown away
   always_ff @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         seen_ff <= 5'h00;
         vld_o   <= 1'b0;
      end
      else if (phi1_i && !phi1_d_ff)
      begin
         if (seen_ff < 5'h14)
            seen_ff <= seen_ff + 5'h01;
         vld_o <= (seen_ff == 5'h14);
      end
   end
endmodule
`default_nettype wire

// *** testbench/tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb;
   import dpa_pkg::*;
   logic                                 clk_i;
   logic                                 arst_n_i;
   logic                                 ce_i;
   logic                                 smp_clk_i = 1'b0;
   logic [CH_NUM-1:0][STG_NUM-1:0][1:0]  stg_code_i;
   logic [CH_NUM-1:0][1:0]               flash_code_i;
   logic                                 phi1_o;
   logic                                 phi2_o;
   logic                                 lat_done_o;
   logic                                 rx_vld;
   logic [CH_NUM-1:0][WORD_W-1:0]        chan_out_o;
   logic [CH_NUM-1:0][WORD_W-1:0]        rx_pair;
   logic [2:0]                           smp_div = 3'h0;
   int                                   bad_count;
   int                                   checks_done;

   dpa_adc_core i_dpa_adc_core
   (
      .clk_i        (clk_i),
      .arst_n_i     (arst_n_i),
      .ce_i         (ce_i),
      .smp_clk_i    (smp_clk_i),
      .stg_code_i   (stg_code_i),
      .flash_code_i (flash_code_i),
      .phi1_o       (phi1_o),
      .phi2_o       (phi2_o),
      .chan_out_o   (chan_out_o),
      .lat_done_o   (lat_done_o)
   );

   dpa_rx_model i_dpa_rx_model
   (
      .clk_i    (clk_i),
      .arst_n_i (arst_n_i),
      .phi1_i   (phi1_o),
      .chan_i   (chan_out_o),
      .pair_o   (rx_pair),
      .vld_o    (rx_vld)
   );

   initial
   begin
      clk_i = 1'b0;
      forever #12.5 clk_i = ~clk_i;
   end

   // sample clock at one eighth of the system clock
   always @(posedge clk_i)
   begin
      smp_div <= smp_div + 3'h1;
      if (smp_div[1:0] == 2'h3)
         smp_clk_i <= ~smp_clk_i;
   end

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         bad_count++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   always @(negedge clk_i)
      if (arst_n_i === 1'b1)
         chk({7'h00, phi1_o & phi2_o}, 8'h00);

   // waits for n phase-one rises, returns one clock later
   task automatic starts(input int n);
      repeat (n)
      begin
         @(posedge phi1_o);
         @(posedge clk_i);
      end
   endtask

   task automatic drive(input logic [11:0] s0, input logic [1:0] f0,
                        input logic [11:0] s1, input logic [1:0] f1);
      stg_code_i   <= {s1, s0};
      flash_code_i <= {f1, f0};
   endtask

   task automatic t_reset();
      chk(chan_out_o[0], 8'h00);
      chk({7'h00, lat_done_o}, 8'h00);
      starts(5);
      chk({7'h00, lat_done_o}, 8'h00);
      starts(2);
      chk({7'h00, lat_done_o}, 8'h01);
   endtask

   task automatic t_phase();
      @(posedge smp_clk_i);
      repeat (2) @(negedge clk_i);
      chk({7'h00, phi1_o}, 8'h00);
      repeat (3) @(negedge clk_i);
      chk({6'h00, phi1_o, phi2_o}, 8'h02);
      // back on a rising edge so the next scenario drives there
      @(posedge clk_i);
   endtask

   task automatic t_codes();
      logic [11:0] sv [6];
      logic [1:0]  fv [6];
      logic [7:0]  ev [6];
      sv = '{12'haaa, 12'h000, 12'h002, 12'h555, 12'hfff, 12'h000};
      fv = '{2'h3, 2'h0, 2'h0, 2'h1, 2'h3, 2'h1};
      ev = '{8'hff, 8'h00, 8'h80, 8'h7f, 8'hff, 8'h01};
      for (int i = 0; i < 6; i++)
      begin
         drive(sv[i], fv[i], sv[5-i], fv[5-i]);
         starts(8);
         chk(chan_out_o[0], ev[i]);
         chk(chan_out_o[1], ev[5-i]);
         chk(rx_pair[0], ev[i]);
         chk(rx_pair[1], ev[5-i]);
      end
   endtask

   // step just after a cycle start: first whole sample shows at start six
   task automatic t_latency(input logic [11:0] s, input logic [1:0] f,
                            input logic [7:0] e);
      drive(s, f, s, f);
      starts(5);
      chk({7'h00, chan_out_o[1] === e}, 8'h00);
      starts(1);
      chk(chan_out_o[0], e);
      chk(chan_out_o[1], e);
      starts(1);
      chk(chan_out_o[0], e);
      chk({7'h00, rx_vld}, 8'h01);
   endtask

   // new codes wait while the enable is low; words must not move.
   // nine sample periods, so the pin is in the same phase on release
   task automatic t_freeze();
      ce_i <= 1'b0;
      drive(12'h000, 2'h0, 12'h000, 2'h0);
      repeat (72) @(posedge clk_i);
      chk(chan_out_o[0], 8'h01);
      chk(chan_out_o[1], 8'hff);
      chk({7'h00, lat_done_o}, 8'h01);
      ce_i <= 1'b1;
   endtask

   task automatic results();
      $display("checks %0d, mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   initial
   begin
      bad_count    = 0;
      checks_done  = 0;
      arst_n_i     = 1'b0;
      ce_i         = 1'b1;
      stg_code_i   = '0;
      flash_code_i = '0;
      repeat (5) @(posedge clk_i);
      arst_n_i <= 1'b1;
      @(posedge clk_i);
      t_reset();
      t_phase();
      t_codes();
      t_freeze();
      drive(12'h000, 2'h0, 12'h000, 2'h0);
      starts(8);
      t_latency(12'haaa, 2'h3, 8'hff);
      starts(1);
      t_latency(12'h000, 2'h0, 8'h00);
      results();
   end

   // run needs about 720 clocks
   initial
   begin
      repeat (20000) @(posedge clk_i);
      bad_count++;
      $display("CHECK FAILED at %0t: watchdog expired", $time);
      results();
   end
endmodule
`default_nettype wire
